// *** chain_regs_pkg.sv ***
package chain_regs_pkg;

    // Holding register numbers
    localparam logic [15:0] ADDR_BITRATE_STATUS = 16'h001b;
    localparam logic [15:0] ADDR_OUT_COUNT_CFG = 16'h001c;
    localparam logic [15:0] ADDR_OUT_COUNT_STATUS = 16'h001d;
    localparam logic [15:0] ADDR_IN_COUNT_CFG = 16'h001e;
    localparam logic [15:0] ADDR_IN_COUNT_STATUS = 16'h001f;
    localparam logic [15:0] ADDR_MODULE_TYPE = 16'h0020;
    localparam logic [15:0] ADDR_FAILSAFE_POLICY = 16'h0021;
    localparam logic [15:0] ADDR_VALIDITY_PERIOD = 16'h0022;

    // Reset values
    localparam logic [7:0] OUT_COUNT_CFG_RESET = 8'h00;
    localparam logic [7:0] IN_COUNT_CFG_RESET = 8'h00;
    localparam logic [7:0] FAILSAFE_POLICY_RESET = 8'h00;
    localparam logic [7:0] VALIDITY_PERIOD_RESET = 8'h00;

    // Legal value limits
    localparam logic [15:0] MAX_MODULES = 16'h0020;
    localparam logic [15:0] POLICY_MAX = 16'h003f;
    localparam logic [15:0] VALIDITY_MAX = 16'h00ff;

    // Fail-safe policy field positions
    localparam int CHAIN_FS_LSB = 0;
    localparam int FIELDBUS_FS_LSB = 2;
    localparam int SERIAL_FS_LSB = 4;

    // Fail-safe encodings
    localparam logic [1:0] FS_ZERO = 2'h0;
    localparam logic [1:0] FS_ONE = 2'h1;
    localparam logic [1:0] FS_HOLD = 2'h2;

    // Bitrate status codes
    localparam logic [1:0] RATE_NONE = 2'h0;

    // Validity timing: period unit is one millisecond
    localparam int CLK_PERIOD_NS = 50;
    localparam int VALIDITY_UNIT_NS = 1000000;
    localparam int MS_CYCLES = VALIDITY_UNIT_NS / CLK_PERIOD_NS;

    // Arbitrary neutral module type value
    localparam logic [7:0] MODULE_TYPE_DEFAULT = 8'h5a;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_RUN = 3'b010,
        ST_ERR = 3'b100
    } chain_state_t;

endpackage : chain_regs_pkg

// *** port_failsafe.sv ***
module port_failsafe #(
    parameter int DATA_W = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [1:0] policy,
    input wire logic stale,
    input wire logic wr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] dout
);

    logic [DATA_W-1:0] last;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            last <= '0;
        else if (wr)
            last <= wdata;
    end

    // Encoding 11 falls into the default and forces zeros
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            dout <= '0;
        else if (!stale)
            dout <= wr ? wdata : last;
        else
        begin
            case (policy)
                chain_regs_pkg::FS_ONE: dout <= '1;
                chain_regs_pkg::FS_HOLD: dout <= last;
                default: dout <= '0;
            endcase
        end
    end

endmodule : port_failsafe

// *** shift_chain_config_regs.sv ***
module shift_chain_config_regs #(
    parameter int MS_CYCLES = chain_regs_pkg::MS_CYCLES,
    parameter int DATA_W = 8,
    parameter logic [7:0] MODULE_TYPE_ID = chain_regs_pkg::MODULE_TYPE_DEFAULT
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [15:0] REG_RDATA,
    output logic REG_ACK,
    output logic REG_ERR,
    input wire logic MASTER_MODE,
    input wire logic AUTO_DETECT,
    input wire logic [1:0] BITRATE_SETTING,
    input wire logic [1:0] SLAVE_RATE,
    input wire logic SLAVE_RATE_VALID,
    input wire logic DETECT_VALID,
    input wire logic [5:0] DETECTED_OUT_COUNT,
    input wire logic [5:0] DETECTED_IN_COUNT,
    output logic CHAIN_ERROR,
    input wire logic CHAIN_PRODUCE,
    output logic CHAIN_DATA_VALID,
    input wire logic FIELDBUS_STALE,
    input wire logic SERIAL_STALE,
    input wire logic CHAIN_OUT_WR,
    input wire logic [DATA_W-1:0] CHAIN_OUT_WDATA,
    output logic [DATA_W-1:0] CHAIN_OUT,
    input wire logic FIELDBUS_OUT_WR,
    input wire logic [DATA_W-1:0] FIELDBUS_OUT_WDATA,
    output logic [DATA_W-1:0] FIELDBUS_OUT,
    input wire logic SERIAL_OUT_WR,
    input wire logic [DATA_W-1:0] SERIAL_OUT_WDATA,
    output logic [DATA_W-1:0] SERIAL_OUT
);

    localparam int MSW = $clog2(MS_CYCLES + 1);

    logic [7:0] out_cfg;
    logic [7:0] in_cfg;
    logic [7:0] policy;
    logic [7:0] period;
    logic [1:0] bitrate_status;
    logic [5:0] out_status;
    logic [5:0] in_status;
    logic [5:0] out_used;
    logic [5:0] in_used;
    logic mismatch;
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic [7:0] elapsed;
    logic next_chain_valid;
    logic wr_ok;
    logic addr_known;
    chain_regs_pkg::chain_state_t state;
    chain_regs_pkg::chain_state_t next_state;

    // Register writes: out-of-range values are refused and leave the register intact
    always_comb
    begin
        case (REG_ADDR)
            chain_regs_pkg::ADDR_OUT_COUNT_CFG,
            chain_regs_pkg::ADDR_IN_COUNT_CFG:
                wr_ok = REG_WDATA <= chain_regs_pkg::MAX_MODULES;
            chain_regs_pkg::ADDR_FAILSAFE_POLICY:
                wr_ok = REG_WDATA <= chain_regs_pkg::POLICY_MAX;
            chain_regs_pkg::ADDR_VALIDITY_PERIOD:
                wr_ok = REG_WDATA <= chain_regs_pkg::VALIDITY_MAX;
            default:
                wr_ok = 1'b0;
        endcase
    end

    assign addr_known = REG_ADDR >= chain_regs_pkg::ADDR_BITRATE_STATUS
        && REG_ADDR <= chain_regs_pkg::ADDR_VALIDITY_PERIOD;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            out_cfg <= chain_regs_pkg::OUT_COUNT_CFG_RESET;
            in_cfg <= chain_regs_pkg::IN_COUNT_CFG_RESET;
            policy <= chain_regs_pkg::FAILSAFE_POLICY_RESET;
            period <= chain_regs_pkg::VALIDITY_PERIOD_RESET;
        end
        else if (REG_WE && wr_ok)
        begin
            case (REG_ADDR)
                chain_regs_pkg::ADDR_OUT_COUNT_CFG: out_cfg <= REG_WDATA[7:0];
                chain_regs_pkg::ADDR_IN_COUNT_CFG: in_cfg <= REG_WDATA[7:0];
                chain_regs_pkg::ADDR_FAILSAFE_POLICY: policy <= REG_WDATA[7:0];
                chain_regs_pkg::ADDR_VALIDITY_PERIOD: period <= REG_WDATA[7:0];
                default: ;
            endcase
        end
    end

    // Reads answer one cycle later; unmapped reads and refused writes flag an error
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            REG_RDATA <= 16'h0000;
            REG_ACK <= 1'b0;
            REG_ERR <= 1'b0;
        end
        else
        begin
            REG_ACK <= REG_RE || REG_WE;
            REG_ERR <= (REG_RE && !addr_known) || (REG_WE && !wr_ok);
            if (REG_RE)
            begin
                case (REG_ADDR)
                    chain_regs_pkg::ADDR_BITRATE_STATUS: REG_RDATA <= {14'h0000, bitrate_status};
                    chain_regs_pkg::ADDR_OUT_COUNT_CFG: REG_RDATA <= {8'h00, out_cfg};
                    chain_regs_pkg::ADDR_OUT_COUNT_STATUS: REG_RDATA <= {10'h000, out_status};
                    chain_regs_pkg::ADDR_IN_COUNT_CFG: REG_RDATA <= {8'h00, in_cfg};
                    chain_regs_pkg::ADDR_IN_COUNT_STATUS: REG_RDATA <= {10'h000, in_status};
                    chain_regs_pkg::ADDR_MODULE_TYPE: REG_RDATA <= {8'h00, MODULE_TYPE_ID};
                    chain_regs_pkg::ADDR_FAILSAFE_POLICY: REG_RDATA <= {8'h00, policy};
                    chain_regs_pkg::ADDR_VALIDITY_PERIOD: REG_RDATA <= {8'h00, period};
                    default: REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end

    // In master mode the device sets the rate itself; in slave mode the far master does
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            bitrate_status <= chain_regs_pkg::RATE_NONE;
        else if (MASTER_MODE)
            bitrate_status <= BITRATE_SETTING;
        else if (SLAVE_RATE_VALID)
            bitrate_status <= SLAVE_RATE;
        else
            bitrate_status <= chain_regs_pkg::RATE_NONE;
    end

    // Valid detected counts win over manual ones, which is why software must turn detection off
    assign out_used = AUTO_DETECT && DETECT_VALID ? DETECTED_OUT_COUNT : out_cfg[5:0];
    assign in_used = AUTO_DETECT && DETECT_VALID ? DETECTED_IN_COUNT : in_cfg[5:0];

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            out_status <= 6'h00;
            in_status <= 6'h00;
        end
        else
        begin
            out_status <= MASTER_MODE ? out_used : 6'h00;
            in_status <= MASTER_MODE ? in_used : 6'h00;
        end
    end

    assign mismatch = DETECT_VALID && !AUTO_DETECT
        && (DETECTED_OUT_COUNT != out_cfg[5:0] || DETECTED_IN_COUNT != in_cfg[5:0]);

    // Error clears once mismatch drops (counts match, detection on or DETECT_VALID low) or master mode is left
    always_comb
    begin
        case (state)
            chain_regs_pkg::ST_OFF:
                next_state = !MASTER_MODE ? chain_regs_pkg::ST_OFF
                    : mismatch ? chain_regs_pkg::ST_ERR : chain_regs_pkg::ST_RUN;
            chain_regs_pkg::ST_RUN,
            chain_regs_pkg::ST_ERR:
                next_state = !MASTER_MODE ? chain_regs_pkg::ST_OFF
                    : mismatch ? chain_regs_pkg::ST_ERR : chain_regs_pkg::ST_RUN;
            default:
                next_state = chain_regs_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            state <= chain_regs_pkg::ST_OFF;
        else
            state <= next_state;
    end

    assign CHAIN_ERROR = state == chain_regs_pkg::ST_ERR;

    // Millisecond time base restarts at each production so the period starts there
    assign ms_tick = ms_cnt == MSW'(MS_CYCLES - 1);

    always_ff @(posedge CLK)
    begin
        if (!RST_N || CHAIN_PRODUCE || ms_tick)
            ms_cnt <= '0;
        else
            ms_cnt <= ms_cnt + 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N || CHAIN_PRODUCE)
            elapsed <= 8'h00;
        else if (ms_tick && elapsed != 8'hff)
            elapsed <= elapsed + 8'h01;
    end

    // Production wins over expiry in the same cycle
    assign next_chain_valid = period == 8'h00 || CHAIN_PRODUCE || elapsed < period;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            CHAIN_DATA_VALID <= 1'b1;
        else
            CHAIN_DATA_VALID <= next_chain_valid;
    end

    // One fallback stage per interface, each with its own policy field
    port_failsafe #(.DATA_W(DATA_W)) u_chain_fs (
        .CLK(CLK),
        .RST_N(RST_N),
        .policy(policy[chain_regs_pkg::CHAIN_FS_LSB +: 2]),
        .stale(!CHAIN_DATA_VALID),
        .wr(CHAIN_OUT_WR),
        .wdata(CHAIN_OUT_WDATA),
        .dout(CHAIN_OUT)
    );

    port_failsafe #(.DATA_W(DATA_W)) u_fieldbus_fs (
        .CLK(CLK),
        .RST_N(RST_N),
        .policy(policy[chain_regs_pkg::FIELDBUS_FS_LSB +: 2]),
        .stale(FIELDBUS_STALE),
        .wr(FIELDBUS_OUT_WR),
        .wdata(FIELDBUS_OUT_WDATA),
        .dout(FIELDBUS_OUT)
    );

    port_failsafe #(.DATA_W(DATA_W)) u_serial_fs (
        .CLK(CLK),
        .RST_N(RST_N),
        .policy(policy[chain_regs_pkg::SERIAL_FS_LSB +: 2]),
        .stale(SERIAL_STALE),
        .wr(SERIAL_OUT_WR),
        .wdata(SERIAL_OUT_WDATA),
        .dout(SERIAL_OUT)
    );

    default clocking cb @(posedge CLK);
    endclocking

    default disable iff (!RST_N);

    property p_rate_none;
        !MASTER_MODE && !SLAVE_RATE_VALID |=> bitrate_status == chain_regs_pkg::RATE_NONE;
    endproperty
    a_rate_none: assert property (p_rate_none) else $error("bitrate not zero when unset");

    property p_slave_rate;
        !MASTER_MODE && SLAVE_RATE_VALID ##1 REG_RE && REG_ADDR == 16'h001b
            |=> REG_RDATA == {14'h0000, $past(SLAVE_RATE, 2)};
    endproperty
    a_slave_rate: assert property (p_slave_rate) else $error("slave rate not reported");

    property p_out_cfg_refuse;
        REG_WE && REG_ADDR == 16'h001c && REG_WDATA > 16'h0020
            |=> REG_ERR && out_cfg == $past(out_cfg);
    endproperty
    a_out_cfg_refuse: assert property (p_out_cfg_refuse) else $error("bad count taken");

    property p_in_cfg_take;
        REG_WE && REG_ADDR == 16'h001e && REG_WDATA <= 16'h0020
            |=> !REG_ERR && in_cfg == $past(REG_WDATA[7:0]);
    endproperty
    a_in_cfg_take: assert property (p_in_cfg_take) else $error("legal count lost");

    property p_mismatch_err;
        MASTER_MODE && mismatch |=> CHAIN_ERROR ##1 (!mismatch || !MASTER_MODE || CHAIN_ERROR);
    endproperty
    a_mismatch_err: assert property (p_mismatch_err) else $error("mismatch without error");

    property p_out_auto;
        MASTER_MODE && AUTO_DETECT && DETECT_VALID |=> out_status == $past(DETECTED_OUT_COUNT);
    endproperty
    a_out_auto: assert property (p_out_auto) else $error("output count not detected");

    property p_in_manual;
        MASTER_MODE && !AUTO_DETECT |=> in_status == $past(in_cfg[5:0]);
    endproperty
    a_in_manual: assert property (p_in_manual) else $error("input count not config");

    property p_type_id;
        REG_RE && REG_ADDR == 16'h0020 |=> REG_ACK && REG_RDATA == {8'h00, MODULE_TYPE_ID};
    endproperty
    a_type_id: assert property (p_type_id) else $error("module type wrong");

    property p_chain_ones;
        !CHAIN_DATA_VALID && policy[1:0] == 2'h1 |=> CHAIN_OUT == '1;
    endproperty
    a_chain_ones: assert property (p_chain_ones) else $error("chain ones not forced");

    property p_fieldbus_hold;
        FIELDBUS_STALE && policy[3:2] == 2'h2 ##1 FIELDBUS_STALE && policy[3:2] == 2'h2
            |=> $stable(FIELDBUS_OUT);
    endproperty
    a_fieldbus_hold: assert property (p_fieldbus_hold) else $error("fieldbus not held");

    property p_serial_undef;
        SERIAL_STALE && policy[5:4] == 2'h3 |=> SERIAL_OUT == '0;
    endproperty
    a_serial_undef: assert property (p_serial_undef) else $error("code 11 not zero");

    property p_expire;
        period != 8'h00 && elapsed >= period && !CHAIN_PRODUCE |=> !CHAIN_DATA_VALID ##1 CHAIN_OUT
            == (policy[1:0] == 2'h1 ? '1 : policy[1:0] == 2'h2 ? $past(CHAIN_OUT) : '0)
            || $past(policy[1:0]) != policy[1:0] || $past(policy[1:0], 2) != policy[1:0]
            || CHAIN_DATA_VALID;
    endproperty
    a_expire: assert property (p_expire) else $error("stale chain data kept valid");

    property p_chain_zero;
        !CHAIN_DATA_VALID && policy[1:0] == 2'h0 |=> CHAIN_OUT == '0;
    endproperty
    a_chain_zero: assert property (p_chain_zero) else $error("fail-safe zero missing");

    property p_never_expire;
        period == 8'h00 |=> CHAIN_DATA_VALID;
    endproperty
    a_never_expire: assert property (p_never_expire) else $error("period zero expired");

    c_error: cover property (MASTER_MODE && mismatch ##1 CHAIN_ERROR);
    c_expire: cover property (CHAIN_DATA_VALID ##1 !CHAIN_DATA_VALID);
    c_reprod: cover property (!CHAIN_DATA_VALID ##1 CHAIN_PRODUCE ##1 CHAIN_DATA_VALID);
    c_refused: cover property (REG_WE ##1 REG_ERR);

endmodule : shift_chain_config_regs

// *** modbus_master_model.sv ***
module modbus_master_model (
    input wire logic CLK,
    output logic [15:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic REG_WE,
    output logic REG_RE,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire logic REG_ERR
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        REG_ADDR = 16'h0000;
        REG_WDATA = 16'hffff;
        REG_WE = 1'b0;
        REG_RE = 1'b0;
    end

    // One holding register access: a one-cycle request, answer one cycle later
    task automatic access(input logic is_write, input logic [15:0] addr,
        input logic [15:0] wdata, output logic [15:0] rdata, output logic ack,
        output logic err);
        @(posedge CLK);
        #1;
        REG_ADDR = addr;
        REG_WDATA = wdata;
        REG_WE = is_write;
        REG_RE = !is_write;
        @(posedge CLK);
        #1;
        REG_WE = 1'b0;
        REG_RE = 1'b0;
        // Idle lines show the inverse so a stale address never looks live
        REG_ADDR = ~addr;
        REG_WDATA = ~wdata;
        rdata = REG_RDATA;
        ack = REG_ACK;
        err = REG_ERR;
    endtask : access
endmodule : modbus_master_model

// *** testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int MS = 8;
    localparam logic [7:0] TYPE_ID = 8'h3c; // Arbitrary identity value
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_we, reg_re, reg_ack, reg_err;
    logic MASTER_MODE = 1'b0, AUTO_DETECT = 1'b0, SLAVE_RATE_VALID = 1'b0, DETECT_VALID = 1'b0;
    logic [1:0] BITRATE_SETTING = 2'h0, SLAVE_RATE = 2'h0;
    logic [5:0] DETECTED_OUT_COUNT = 6'h00, DETECTED_IN_COUNT = 6'h00;
    logic CHAIN_ERROR, CHAIN_DATA_VALID, CHAIN_PRODUCE = 1'b0;
    logic FIELDBUS_STALE = 1'b0, SERIAL_STALE = 1'b0;
    logic CHAIN_OUT_WR = 1'b0, FIELDBUS_OUT_WR = 1'b0, SERIAL_OUT_WR = 1'b0;
    logic [7:0] CHAIN_OUT_WDATA = 8'h00, FIELDBUS_OUT_WDATA = 8'h00, SERIAL_OUT_WDATA = 8'h00;
    logic [7:0] CHAIN_OUT, FIELDBUS_OUT, SERIAL_OUT;
    int errors = 0;
    int samples_checked = 0;

    always #25 CLK = ~CLK;

    shift_chain_config_regs #(.MS_CYCLES(MS), .DATA_W(8), .MODULE_TYPE_ID(TYPE_ID)) DUT (
        .CLK(CLK), .RST_N(RST_N), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
        .REG_ERR(reg_err), .MASTER_MODE(MASTER_MODE), .AUTO_DETECT(AUTO_DETECT),
        .BITRATE_SETTING(BITRATE_SETTING), .SLAVE_RATE(SLAVE_RATE),
        .SLAVE_RATE_VALID(SLAVE_RATE_VALID), .DETECT_VALID(DETECT_VALID),
        .DETECTED_OUT_COUNT(DETECTED_OUT_COUNT), .DETECTED_IN_COUNT(DETECTED_IN_COUNT),
        .CHAIN_ERROR(CHAIN_ERROR), .CHAIN_PRODUCE(CHAIN_PRODUCE),
        .CHAIN_DATA_VALID(CHAIN_DATA_VALID), .FIELDBUS_STALE(FIELDBUS_STALE),
        .SERIAL_STALE(SERIAL_STALE), .CHAIN_OUT_WR(CHAIN_OUT_WR),
        .CHAIN_OUT_WDATA(CHAIN_OUT_WDATA), .CHAIN_OUT(CHAIN_OUT),
        .FIELDBUS_OUT_WR(FIELDBUS_OUT_WR), .FIELDBUS_OUT_WDATA(FIELDBUS_OUT_WDATA),
        .FIELDBUS_OUT(FIELDBUS_OUT), .SERIAL_OUT_WR(SERIAL_OUT_WR),
        .SERIAL_OUT_WDATA(SERIAL_OUT_WDATA), .SERIAL_OUT(SERIAL_OUT)
    );

    modbus_master_model master (
        .CLK(CLK), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we),
        .REG_RE(reg_re), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .REG_ERR(reg_err)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : step

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic exp_err);
        logic [15:0] r;
        logic k;
        logic e;
        master.access(1'b1, a, d, r, k, e);
        check("write ack", {15'h0000, k}, 16'h0001);
        check("write err", {15'h0000, e}, {15'h0000, exp_err});
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic exp_err);
        logic [15:0] r;
        logic k;
        logic e;
        master.access(1'b0, a, 16'h0000, r, k, e);
        check("read ack", {15'h0000, k}, 16'h0001);
        check("read err", {15'h0000, e}, {15'h0000, exp_err});
        check("read data", r, exp);
    endtask : rd

    function automatic logic [7:0] fs_expect(input logic [1:0] enc, input logic [7:0] last);
        case (enc)
            2'h1: return 8'hff;
            2'h2: return last;
            default: return 8'h00;
        endcase
    endfunction : fs_expect

    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        logic [15:0] v, w;
        logic [31:0] d;
        logic [5:0] pol;
        void'($urandom(23980));
        step(20);
        RST_N = 1'b1;
        rd(chain_regs_pkg::ADDR_OUT_COUNT_CFG, 16'h0000, 1'b0);
        rd(chain_regs_pkg::ADDR_IN_COUNT_CFG, 16'h0000, 1'b0);
        rd(chain_regs_pkg::ADDR_FAILSAFE_POLICY, 16'h0000, 1'b0);
        rd(chain_regs_pkg::ADDR_VALIDITY_PERIOD, 16'h0000, 1'b0);
        rd(chain_regs_pkg::ADDR_MODULE_TYPE, {8'h00, TYPE_ID}, 1'b0);
        wr(chain_regs_pkg::ADDR_MODULE_TYPE, 16'h0011, 1'b1);
        rd(chain_regs_pkg::ADDR_MODULE_TYPE, {8'h00, TYPE_ID}, 1'b0);
        wr(chain_regs_pkg::ADDR_BITRATE_STATUS, 16'h0002, 1'b1);
        wr(chain_regs_pkg::ADDR_OUT_COUNT_STATUS, 16'h0003, 1'b1);
        wr(chain_regs_pkg::ADDR_IN_COUNT_STATUS, 16'h0003, 1'b1);
        rd(16'h0023, 16'h0000, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 16'h0020 : 16'($urandom_range(32, 0));
            w = (i == 1) ? 16'h0020 : 16'($urandom_range(32, 0));
            wr(chain_regs_pkg::ADDR_OUT_COUNT_CFG, v, 1'b0);
            wr(chain_regs_pkg::ADDR_IN_COUNT_CFG, w, 1'b0);
            rd(chain_regs_pkg::ADDR_OUT_COUNT_CFG, v, 1'b0);
            rd(chain_regs_pkg::ADDR_IN_COUNT_CFG, w, 1'b0);
        end
        wr(chain_regs_pkg::ADDR_OUT_COUNT_CFG, 16'h0021, 1'b1);
        wr(chain_regs_pkg::ADDR_IN_COUNT_CFG, 16'h0021, 1'b1);
        rd(chain_regs_pkg::ADDR_OUT_COUNT_CFG, v, 1'b0);
        MASTER_MODE = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            BITRATE_SETTING = 2'(c);
            rd(chain_regs_pkg::ADDR_BITRATE_STATUS, 16'(c), 1'b0);
        end
        MASTER_MODE = 1'b0;
        SLAVE_RATE_VALID = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            SLAVE_RATE = 2'(c);
            BITRATE_SETTING = ~2'(c);
            rd(chain_regs_pkg::ADDR_BITRATE_STATUS, 16'(c), 1'b0);
        end
        SLAVE_RATE_VALID = 1'b0;
        rd(chain_regs_pkg::ADDR_BITRATE_STATUS, 16'h0000, 1'b0);
        MASTER_MODE = 1'b1;
        AUTO_DETECT = 1'b1;
        DETECT_VALID = 1'b1;
        DETECTED_OUT_COUNT = 6'($urandom_range(32, 0));
        DETECTED_IN_COUNT = 6'h20;
        rd(chain_regs_pkg::ADDR_OUT_COUNT_STATUS, {10'h000, DETECTED_OUT_COUNT}, 1'b0);
        rd(chain_regs_pkg::ADDR_IN_COUNT_STATUS, 16'h0020, 1'b0);
        check("auto error", {15'h0000, CHAIN_ERROR}, 16'h0000);
        // Manual counts count when detection is off or DETECT_VALID is low
        AUTO_DETECT = 1'b0;
        DETECTED_OUT_COUNT = v[5:0];
        DETECTED_IN_COUNT = w[5:0];
        step(2);
        check("match error", {15'h0000, CHAIN_ERROR}, 16'h0000);
        rd(chain_regs_pkg::ADDR_IN_COUNT_STATUS, {10'h000, w[5:0]}, 1'b0);
        DETECTED_OUT_COUNT = v[5:0] + 6'h01;
        step(2);
        check("out mismatch", {15'h0000, CHAIN_ERROR}, 16'h0001);
        DETECTED_OUT_COUNT = v[5:0];
        DETECTED_IN_COUNT = w[5:0] ^ 6'h01;
        step(2);
        check("in mismatch", {15'h0000, CHAIN_ERROR}, 16'h0001);
        MASTER_MODE = 1'b0;
        step(2);
        check("slave error", {15'h0000, CHAIN_ERROR}, 16'h0000);
        rd(chain_regs_pkg::ADDR_OUT_COUNT_STATUS, 16'h0000, 1'b0);
        wr(chain_regs_pkg::ADDR_VALIDITY_PERIOD, 16'h0100, 1'b1);
        wr(chain_regs_pkg::ADDR_FAILSAFE_POLICY, 16'h0040, 1'b1);
        wr(chain_regs_pkg::ADDR_VALIDITY_PERIOD, 16'h0001, 1'b0);
        for (int enc = 0; enc < 4; enc++)
        begin
            pol = {2'(enc + 2), 2'(enc + 1), 2'(enc)};
            wr(chain_regs_pkg::ADDR_FAILSAFE_POLICY, {10'h000, pol}, 1'b0);
            rd(chain_regs_pkg::ADDR_FAILSAFE_POLICY, {10'h000, pol}, 1'b0);
            FIELDBUS_STALE = 1'b0;
            SERIAL_STALE = 1'b0;
            CHAIN_PRODUCE = 1'b1;
            step(1);
            CHAIN_PRODUCE = 1'b0;
            d = $urandom;
            CHAIN_OUT_WDATA = d[7:0];
            FIELDBUS_OUT_WDATA = d[15:8];
            SERIAL_OUT_WDATA = d[23:16];
            {CHAIN_OUT_WR, FIELDBUS_OUT_WR, SERIAL_OUT_WR} = 3'h7;
            step(1);
            {CHAIN_OUT_WR, FIELDBUS_OUT_WR, SERIAL_OUT_WR} = 3'h0;
            step(1);
            check("valid fresh", {15'h0000, CHAIN_DATA_VALID}, 16'h0001);
            check("chain live", {8'h00, CHAIN_OUT}, {8'h00, d[7:0]});
            check("fieldbus live", {8'h00, FIELDBUS_OUT}, {8'h00, d[15:8]});
            check("serial live", {8'h00, SERIAL_OUT}, {8'h00, d[23:16]});
            FIELDBUS_STALE = 1'b1;
            SERIAL_STALE = 1'b1;
            step(20);
            check("valid lapsed", {15'h0000, CHAIN_DATA_VALID}, 16'h0000);
            check("chain safe", {8'h00, CHAIN_OUT}, {8'h00, fs_expect(pol[1:0], d[7:0])});
            check("fieldbus safe", {8'h00, FIELDBUS_OUT}, {8'h00, fs_expect(pol[3:2], d[15:8])});
            check("serial safe", {8'h00, SERIAL_OUT}, {8'h00, fs_expect(pol[5:4], d[23:16])});
        end
        CHAIN_PRODUCE = 1'b1;
        step(1);
        CHAIN_PRODUCE = 1'b0;
        step(2);
        check("valid again", {15'h0000, CHAIN_DATA_VALID}, 16'h0001);
        check("chain back", {8'h00, CHAIN_OUT}, {8'h00, d[7:0]});
        wr(chain_regs_pkg::ADDR_VALIDITY_PERIOD, 16'h0000, 1'b0);
        step(60);
        check("never expires", {15'h0000, CHAIN_DATA_VALID}, 16'h0001);
        wrap_up();
    end

    // The whole sequence needs well under a thousand cycles; five thousand flags a hang
    initial
    begin
        #(50 * 5000);
        errors++;
        wrap_up();
    end
endmodule : testbench
